// >>> design/bstp_pkg.sv
// Package with the constants, states and carriers of the boundary-scan test port.
package bstp_pkg;
   localparam int BSTP_SYNC_STAGES = 2;
   localparam int BSTP_IR_WIDTH = 3;
   localparam int BSTP_ID_WIDTH = 32;
   // Instruction codes; all ones selects the bypass path as usual.
   localparam logic [BSTP_IR_WIDTH-1:0] BSTP_INSTR_IDCODE = 3'h1;
   localparam logic [BSTP_IR_WIDTH-1:0] BSTP_INSTR_BYPASS = 3'h7;
   // Fixed pattern loaded into the instruction shifter on capture.
   localparam logic [BSTP_IR_WIDTH-1:0] BSTP_IR_CAPTURE = 3'h1;
   // Identification word; the value is arbitrary, bit zero set as required.
   localparam logic [BSTP_ID_WIDTH-1:0] BSTP_ID_VALUE = 32'h0000_0001;
   localparam logic [BSTP_ID_WIDTH-1:0] BSTP_ID_ZERO = 32'h0000_0000;

   typedef enum logic [3:0] {
      BSTP_TLR = 4'hF,
      BSTP_RTI = 4'hC,
      BSTP_SEL_DR = 4'h7,
      BSTP_CAP_DR = 4'h6,
      BSTP_SH_DR = 4'h2,
      BSTP_EX1_DR = 4'h1,
      BSTP_PAU_DR = 4'h3,
      BSTP_EX2_DR = 4'h0,
      BSTP_UPD_DR = 4'h5,
      BSTP_SEL_IR = 4'h4,
      BSTP_CAP_IR = 4'hE,
      BSTP_SH_IR = 4'hA,
      BSTP_EX1_IR = 4'h9,
      BSTP_PAU_IR = 4'hB,
      BSTP_EX2_IR = 4'h8,
      BSTP_UPD_IR = 4'hD
   } bstp_state_e;

   // Levels of the four test port inputs after the pull-ups are applied.
   typedef struct packed {
      logic reset;
      logic clock;
      logic mode;
      logic data;
   } bstp_pins_s;
endpackage : bstp_pkg

// >>> design/bstp_test_port.sv
// Boundary-scan test access port sampled on the core clock.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Test reset forces the port controller to reset with no test clock edge.
// - Rising test reset enters identification mode with the identification path selected.
// - Test reset low restores normal operation; controller holds it low outside testing.
// - Mode select sampled on each test clock rise steers the sixteen states.
// - Serial input bits are captured on the test clock rising edge.
// - Serial output bits change on the test clock falling edge.
// - Undriven test reset, mode select and serial input read as high.
module bstp_test_port
   import bstp_pkg::*;
(
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic test_port_reset,
   input wire logic test_port_reset_drive,
   input wire logic test_clock_in,
   input wire logic test_mode_select_in,
   input wire logic test_mode_select_drive,
   input wire logic test_serial_in,
   input wire logic test_serial_in_drive,
   output logic test_serial_out,
   output logic test_serial_out_oe,
   output logic test_mode_active,
   output logic id_path_selected,
   output bstp_state_e tap_state
);

   ////////////////////////////////////////////////////////////////////////////
   // Pull-ups and synchronisers.

   bstp_pins_s pin_level;
   bstp_pins_s sync_first;
   bstp_pins_s sync_second;
   bstp_pins_s sync_prev;
   logic tck_rise;
   logic tck_fall;
   logic port_hold;
   logic reset_rise;

   // A pin that nobody drives reads high, as its pull-up would make it.
   always_comb
   begin
      pin_level.reset = test_port_reset_drive ? test_port_reset : 1'b1;
      pin_level.mode = test_mode_select_drive ? test_mode_select_in : 1'b1;
      pin_level.data = test_serial_in_drive ? test_serial_in : 1'b1;
      pin_level.clock = test_clock_in;
   end

   // Two flip-flops settle each pin; the third stage only feeds the edge detectors.
   // Clearing all stages to low keeps a false test clock edge from following core reset.
   always_ff @(posedge core_clk)
   begin
      if (!rstn)
      begin
         sync_first <= '0;
         sync_second <= '0;
         sync_prev <= '0;
      end
      else
      begin
         sync_first <= pin_level;
         sync_second <= sync_first;
         sync_prev <= sync_second;
      end
   end

   assign tck_rise = sync_second.clock & ~sync_prev.clock;
   assign tck_fall = ~sync_second.clock & sync_prev.clock;
   // The port is held while the test reset is low, independent of the test clock.
   assign port_hold = ~rstn | ~sync_second.reset;
   // A rising test reset is what enters identification mode.
   assign reset_rise = sync_second.reset & ~sync_prev.reset;

   ////////////////////////////////////////////////////////////////////////////
   // Port controller state machine.

   // Transitions follow the test clock rise as seen on the core clock, so the
   // controller trails the pin by two to three core clocks.
   bstp_state_e next_state;

   always_comb
   begin
      next_state = tap_state;
      unique case (tap_state)
         BSTP_TLR: next_state = sync_second.mode ? BSTP_TLR : BSTP_RTI;
         BSTP_RTI: next_state = sync_second.mode ? BSTP_SEL_DR : BSTP_RTI;
         BSTP_SEL_DR: next_state = sync_second.mode ? BSTP_SEL_IR : BSTP_CAP_DR;
         BSTP_CAP_DR: next_state = sync_second.mode ? BSTP_EX1_DR : BSTP_SH_DR;
         BSTP_SH_DR: next_state = sync_second.mode ? BSTP_EX1_DR : BSTP_SH_DR;
         BSTP_EX1_DR: next_state = sync_second.mode ? BSTP_UPD_DR : BSTP_PAU_DR;
         BSTP_PAU_DR: next_state = sync_second.mode ? BSTP_EX2_DR : BSTP_PAU_DR;
         BSTP_EX2_DR: next_state = sync_second.mode ? BSTP_UPD_DR : BSTP_SH_DR;
         BSTP_UPD_DR: next_state = sync_second.mode ? BSTP_SEL_DR : BSTP_RTI;
         BSTP_SEL_IR: next_state = sync_second.mode ? BSTP_TLR : BSTP_CAP_IR;
         BSTP_CAP_IR: next_state = sync_second.mode ? BSTP_EX1_IR : BSTP_SH_IR;
         BSTP_SH_IR: next_state = sync_second.mode ? BSTP_EX1_IR : BSTP_SH_IR;
         BSTP_EX1_IR: next_state = sync_second.mode ? BSTP_UPD_IR : BSTP_PAU_IR;
         BSTP_PAU_IR: next_state = sync_second.mode ? BSTP_EX2_IR : BSTP_PAU_IR;
         BSTP_EX2_IR: next_state = sync_second.mode ? BSTP_UPD_IR : BSTP_SH_IR;
         BSTP_UPD_IR: next_state = sync_second.mode ? BSTP_SEL_DR : BSTP_RTI;
      endcase
   end

   // Holding the port wins over any test clock edge in the same core cycle.
   always_ff @(posedge core_clk)
   begin
      if (port_hold)
         tap_state <= BSTP_TLR;
      else if (tck_rise)
         tap_state <= next_state;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Instruction path.

   logic [BSTP_IR_WIDTH-1:0] instr;
   logic [BSTP_IR_WIDTH-1:0] instr_shift;

   always_ff @(posedge core_clk)
   begin
      if (port_hold)
         instr_shift <= BSTP_IR_CAPTURE;
      else if (tck_rise && tap_state == BSTP_CAP_IR)
         instr_shift <= BSTP_IR_CAPTURE;
      else if (tck_rise && tap_state == BSTP_SH_IR)
         instr_shift <= {sync_second.data, instr_shift[BSTP_IR_WIDTH-1:1]};
   end

   // Any code other than identification selects the one-bit bypass path.
   always_ff @(posedge core_clk)
   begin
      if (port_hold)
         instr <= BSTP_INSTR_IDCODE;
      else if (tck_rise && tap_state == BSTP_TLR)
         instr <= BSTP_INSTR_IDCODE;
      else if (tck_rise && tap_state == BSTP_UPD_IR)
         instr <= instr_shift;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Data paths: identification word and bypass bit.

   // The identification word loads on capture and leaves low bit first.
   // The shifter is cleared while the port is held.
   logic [BSTP_ID_WIDTH-1:0] id_shift;
   logic bypass_bit;
   logic id_sel;

   assign id_sel = (instr == BSTP_INSTR_IDCODE);

   always_ff @(posedge core_clk)
   begin
      if (port_hold)
      begin
         id_shift <= BSTP_ID_ZERO;
         bypass_bit <= 1'b0;
      end
      else if (tck_rise && tap_state == BSTP_CAP_DR)
      begin
         id_shift <= BSTP_ID_VALUE;
         bypass_bit <= 1'b0;
      end
      else if (tck_rise && tap_state == BSTP_SH_DR)
      begin
         if (id_sel)
            id_shift <= {sync_second.data, id_shift[BSTP_ID_WIDTH-1:1]};
         else
            bypass_bit <= sync_second.data;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Serial output, driven on the falling test clock edge.
   // Changing only after a falling edge leaves the bit settled for the next rising edge.
   // The bit keeps its last value while the enable is low, unless the port is held, which clears it to low.

   always_ff @(posedge core_clk)
   begin
      if (port_hold)
      begin
         test_serial_out <= 1'b0;
         test_serial_out_oe <= 1'b0;
      end
      else if (tck_fall)
      begin
         test_serial_out_oe <= (tap_state == BSTP_SH_DR) || (tap_state == BSTP_SH_IR);
         if (tap_state == BSTP_SH_IR)
            test_serial_out <= instr_shift[0];
         else if (tap_state == BSTP_SH_DR)
            test_serial_out <= id_sel ? id_shift[0] : bypass_bit;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Mode flags seen by the rest of the device.
   // Test mode lasts until the test reset goes low, which returns normal operation.

   always_ff @(posedge core_clk)
   begin
      if (port_hold)
         test_mode_active <= 1'b0;
      else if (reset_rise)
         test_mode_active <= 1'b1;
   end

   always_ff @(posedge core_clk)
   begin
      if (port_hold)
         id_path_selected <= 1'b0;
      else
         id_path_selected <= id_sel;
   end

endmodule : bstp_test_port
`default_nettype wire

// >>> dv/bstp_ctrl_model.sv
// External boundary-scan controller driving the test port pins.
`timescale 1ns/1ps
`default_nettype none
module bstp_ctrl_model
(
   input wire logic core_clk,
   output logic trst = 1'b0,
   output logic trst_drv = 1'b1,
   output logic tck = 1'b0,
   output logic tms = 1'b1,
   output logic tms_drv = 1'b1,
   output logic tdi = 1'b0,
   output logic tdi_drv = 1'b1,
   input wire logic tdo
);
   // Reset starts low and is raised only by the bench.
   task automatic pins(input logic r, rd, md, dd);
      @(posedge core_clk);
      trst <= r;
      trst_drv <= rd;
      tms_drv <= md;
      tdi_drv <= dd;
      repeat (5) @(posedge core_clk);
   endtask : pins
   // A released line shows the inverse of its last value.
   // One tick is 32 core clocks, a test clock period of 160 ns.
   task automatic tick(input logic m, d, output logic o);
      @(posedge core_clk);
      tms <= tms_drv ? m : ~tms;
      tdi <= tdi_drv ? d : ~tdi;
      repeat (8) @(posedge core_clk);
      o = tdo;
      tck <= 1'b1;
      repeat (16) @(posedge core_clk);
      tck <= 1'b0;
      repeat (7) @(posedge core_clk);
   endtask : tick
endmodule : bstp_ctrl_model
`default_nettype wire

// >>> dv/bstp_test_port_properties.sv
// Concurrent checks on the ports of the boundary-scan test port.
`timescale 1ns/1ps
`default_nettype none
module bstp_test_port_properties
   import bstp_pkg::*;
(
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic test_port_reset,
   input wire logic test_port_reset_drive,
   input wire logic test_clock_in,
   input wire logic test_serial_out,
   input wire logic test_serial_out_oe,
   input wire logic test_mode_active,
   input wire logic id_path_selected,
   input wire bstp_state_e tap_state
);
   wire logic trst_eff = !test_port_reset_drive || test_port_reset;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rstn);
   a_trst_forces_tlr: assert property (!trst_eff [*3] |=> tap_state == BSTP_TLR)
      else $error("state not reset by test reset");
   a_trst_ends_test: assert property (!trst_eff [*3] |=> !test_mode_active)
      else $error("test mode kept under test reset");
   a_trst_rise_mode: assert property ($rose(trst_eff) |-> ##[1:4] test_mode_active)
      else $error("test mode not entered");
   a_entry_id_path: assert property ($rose(test_mode_active) |-> ##[0:1] id_path_selected)
      else $error("id path not selected on entry");
   a_state_on_rise: assert property ($changed(tap_state) && tap_state != BSTP_TLR
      |-> test_clock_in)
      else $error("state moved without test clock rise");
   a_out_on_fall: assert property ($changed(test_serial_out) |-> !test_clock_in)
      else $error("serial out changed while clock high");
   a_oe_shift_rise: assert property ($rose(test_serial_out_oe)
      |-> tap_state inside {BSTP_SH_DR, BSTP_SH_IR})
      else $error("output enabled outside shift");
   a_oe_shift_fall: assert property ($fell(test_serial_out_oe)
      |-> !(tap_state inside {BSTP_SH_DR, BSTP_SH_IR}))
      else $error("output disabled while shifting");
   a_oe_needs_mode: assert property (test_serial_out_oe |-> test_mode_active)
      else $error("output enabled in normal operation");
   c_shift_dr: cover property (tap_state == BSTP_SH_DR && test_serial_out_oe);
   c_shift_ir: cover property (tap_state == BSTP_SH_IR && test_serial_out_oe);
   c_mode_entry: cover property ($rose(test_mode_active));
endmodule : bstp_test_port_properties
bind bstp_test_port bstp_test_port_properties p_u (.*);
`default_nettype wire

// >>> dv/bstp_test_port_tb.sv
// Self-checking bench for the boundary-scan test port.
`timescale 1ns/1ps
`default_nettype none
module bstp_test_port_tb;
   import bstp_pkg::*;
   logic core_clk = 1'b0;
   logic rstn = 1'b0;
   logic tdo, oe, act, idp, o;
   logic [31:0] d;
   wire logic trst, trd, tck, tms, tmd, tdi, tdd;
   bstp_state_e st;
   int n_errors = 0;
   int n_checks = 0;
   always #2.5 core_clk = ~core_clk;
   bstp_ctrl_model m_u (.core_clk(core_clk), .trst(trst), .trst_drv(trd), .tck(tck),
      .tms(tms), .tms_drv(tmd), .tdi(tdi), .tdi_drv(tdd), .tdo(tdo));
   bstp_test_port dut_u (.core_clk(core_clk), .rstn(rstn), .test_port_reset(trst),
      .test_port_reset_drive(trd), .test_clock_in(tck), .test_mode_select_in(tms),
      .test_mode_select_drive(tmd), .test_serial_in(tdi), .test_serial_in_drive(tdd),
      .test_serial_out(tdo), .test_serial_out_oe(oe), .test_mode_active(act),
      .id_path_selected(idp), .tap_state(st));
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      n_checks++;
      if (s !== e)
      begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic walk(input logic [3:0] tm);
      for (int i = 3; i >= 0; i--) m_u.tick(tm[i], 1'b0, o);
   endtask : walk
   // Shifts n bits LSB first, leaving the shift state on the last one.
   task automatic shift(input int n, input logic [31:0] din);
      d = '0;
      for (int i = 0; i < n; i++)
      begin
         m_u.tick(i == n - 1, din[i], o);
         d[i] = o;
      end
   endtask : shift
   task automatic t_entry;
      m_u.pins(1'b1, 1'b1, 1'b1, 1'b1);
      chk("mode", 1, act);
      chk("id_path", 1, idp);
      walk(4'b0100);
      chk("state", BSTP_SH_DR, st);
      shift(32, 32'h0);
      chk("idcode", BSTP_ID_VALUE, d);
      walk(4'b1000);
      chk("oe", 0, oe);
      walk(4'b1100);
      shift(3, BSTP_INSTR_BYPASS);
      chk("ir_capture", BSTP_IR_CAPTURE, d);
      walk(4'b1000);
      chk("id_path", 0, idp);
   endtask : t_entry
   task automatic t_bypass;
      walk(4'b0100);
      shift(8, 32'hA5);
      chk("bypass", 32'h4A, d);
      walk(4'b0100);
      m_u.pins(1'b1, 1'b1, 1'b1, 1'b0);
      shift(8, 32'h0);
      chk("tdi_pullup", 32'hFE, d);
      m_u.pins(1'b1, 1'b1, 1'b1, 1'b1);
      walk(4'b1000);
      m_u.pins(1'b0, 1'b1, 1'b1, 1'b1);
      chk("trst_state", BSTP_TLR, st);
      chk("trst_mode", 0, act);
      chk("trst_oe", 0, oe);
   endtask : t_bypass
   task automatic t_pullup;
      m_u.pins(1'b0, 1'b0, 1'b1, 1'b1);
      chk("trst_pullup", 1, act);
      walk(4'b0000);
      m_u.pins(1'b0, 1'b0, 1'b0, 1'b1);
      walk(4'b0000);
      chk("tms_pullup", BSTP_TLR, st);
   endtask : t_pullup
   task automatic results;
      if (n_errors == 0 && n_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : results
   initial
   begin
      repeat (10) @(posedge core_clk);
      rstn <= 1'b1;
      repeat (4) @(posedge core_clk);
      t_entry();
      t_bypass();
      t_pullup();
      results();
   end
   initial
   begin
      #200us;
      n_errors++;
      results();
   end
endmodule : bstp_test_port_tb
`default_nettype wire
